//--- touch_ctrl_pkg.sv
`default_nettype none
package touch_ctrl_pkg;
  localparam int NUM_CH   = 8;
  localparam int CH_IDX_W = 3;
  localparam int TIMER_W  = 12;
  localparam int CLK_MHZ  = 50;

  // opcodes
  localparam logic [7:0] OP_SOFT_RESET = 8'h00;
  localparam logic [7:0] OP_CLR_INT    = 8'h03;
  localparam logic [7:0] OP_SLEEP      = 8'h05;
  localparam logic [7:0] OP_WAKE       = 8'h06;
  localparam logic [7:0] OP_WR_SETUP   = 8'h30;
  localparam logic [7:0] OP_RD_SETUP   = 8'h33;
  localparam logic [7:0] OP_WR_TUNE    = 8'h35;
  localparam logic [7:0] OP_RD_TUNE    = 8'h36;
  localparam logic [7:0] OP_WR_CHMASK  = 8'h39;
  localparam logic [7:0] OP_RD_CHMASK  = 8'h3a;
  localparam logic [7:0] OP_INT_BUS    = 8'h3c;

  // register reset values
  localparam logic [7:0] SETUP_RST  = 8'h00;
  localparam logic [7:0] TUNE_RST   = 8'h0c;
  localparam logic [7:0] CHMASK_RST = 8'hff;
  localparam logic [7:0] TOUCH_RST  = 8'h00;

  // setup register fields
  localparam int OPM_HI   = 7;
  localparam int OPM_LO   = 6;
  localparam int SWM_BIT  = 5;
  localparam int INTM_BIT = 1;
  localparam logic [1:0] OPM_SECONDARY = 2'h1;
  localparam logic [1:0] OPM_PRIMARY   = 2'h2;

  // upper six bits of the 7-bit bus address
  localparam logic [5:0] ADDR_BASE = 6'h1d;

  // run of equal-direction steps that marks a channel active
  localparam logic [6:0] ACT_RUN = 7'h40;

  // pin synchroniser: {scl, sda, addr select, sleep, ref, sense[7:0]}
  localparam int SYNC_W = 4 + NUM_CH + 1;
  localparam logic [SYNC_W-1:0] SYNC_RST = 13'h1800;

  // timing
  localparam int STARTUP_US = 50;
  localparam int CHARGE_NS  = 200;
  localparam int RACE_NS    = 2000;
  localparam int GAP_NS     = 1000;
  localparam logic [TIMER_W-1:0] STARTUP_CYC = TIMER_W'(STARTUP_US * CLK_MHZ);
  localparam logic [TIMER_W-1:0] CHARGE_CYC  = TIMER_W'((CHARGE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TIMER_W-1:0] RACE_CYC    = TIMER_W'((RACE_NS * CLK_MHZ) / 1000);
  localparam logic [TIMER_W-1:0] GAP_CYC     = TIMER_W'((GAP_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic [1:0] {SRC_SENSOR, SRC_SETUP, SRC_TUNE, SRC_CHMASK} rd_src_t;
endpackage
`default_nettype wire

//--- i2c_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface i2c_cmd_if;
  logic       evt_op;
  logic       evt_wr;
  logic       rd_start;
  logic       rd_next;
  logic [7:0] data_byte;
  logic       sda_drive;
  logic [7:0] rd_data;
  logic       rd_skip;

  modport target (
    output evt_op, evt_wr, rd_start, rd_next, data_byte, sda_drive,
    input  rd_data, rd_skip
  );
  modport ctrl (
    input  evt_op, evt_wr, rd_start, rd_next, data_byte, sda_drive,
    output rd_data, rd_skip
  );
endinterface
`default_nettype wire

//--- channel_run.sv
`timescale 1ns/1ps
`default_nettype none
module channel_run (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic up_i,
  input  wire logic down_i,
  output logic      active_o
);
  import touch_ctrl_pkg::*;

  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic       dir_up_ff;
  logic       nxt_dir_up;
  logic       active_ff;
  logic       nxt_active;

  always_comb
  begin
    nxt_cnt    = cnt_ff;
    nxt_dir_up = dir_up_ff;
    nxt_active = active_ff;
    if (up_i)
    begin
      nxt_dir_up = 1'b1;
      if (!dir_up_ff)
        nxt_cnt = 7'h01;
      else if (cnt_ff != ACT_RUN)
        nxt_cnt = cnt_ff + 7'h01;
      if (dir_up_ff && cnt_ff + 7'h01 >= ACT_RUN)
        nxt_active = 1'b1;
    end
    else if (down_i)
    begin
      nxt_dir_up = 1'b0;
      if (dir_up_ff)
      begin
        nxt_cnt    = 7'h01;
        nxt_active = 1'b0;
      end
      else if (cnt_ff != ACT_RUN)
        nxt_cnt = cnt_ff + 7'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff    <= 7'h00;
      dir_up_ff <= 1'b0;
      active_ff <= 1'b0;
    end
    else
    begin
      cnt_ff    <= nxt_cnt;
      dir_up_ff <= nxt_dir_up;
      active_ff <= nxt_active;
    end
  end

  assign active_o = active_ff;
endmodule
`default_nettype wire

//--- i2c_target.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_target (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [6:0] own_addr_i,
  i2c_cmd_if.target       ifc
);
  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_ADDR_ACK, T_WR, T_WR_ACK, T_RD, T_RD_ACK} tstate_t;

  tstate_t    st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic       drv_ff, nxt_drv;
  logic       rw_ff, nxt_rw;
  logic       first_ff, nxt_first;
  logic       skip_ff, nxt_skip;
  logic       scl_d_ff, sda_d_ff;
  logic       op_ff, nxt_op, wr_ff, nxt_wr, rs_ff, nxt_rs, rn_ff, nxt_rn;
  logic       rise, fall, start, stop;

  assign rise  = scl_i & ~scl_d_ff;
  assign fall  = ~scl_i & scl_d_ff;
  assign start = scl_i & scl_d_ff & sda_d_ff & ~sda_i;
  assign stop  = scl_i & scl_d_ff & ~sda_d_ff & sda_i;

  always_comb
  begin
    nxt_st = st_ff; nxt_cnt = cnt_ff; nxt_sh = sh_ff; nxt_drv = drv_ff;
    nxt_rw = rw_ff; nxt_first = first_ff; nxt_skip = skip_ff;
    nxt_op = 1'b0; nxt_wr = 1'b0; nxt_rs = 1'b0; nxt_rn = 1'b0;
    if (start)
    begin
      nxt_st = T_ADDR; nxt_cnt = 4'h0; nxt_drv = 1'b0; nxt_first = 1'b1;
    end
    else if (stop)
    begin
      nxt_st = T_IDLE; nxt_drv = 1'b0;
    end
    else
    begin
      unique case (st_ff)
        T_IDLE: ;
        T_ADDR, T_WR:
          if (rise)
          begin
            nxt_sh  = {sh_ff[6:0], sda_i};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (fall && cnt_ff == 4'h8)
          begin
            if (st_ff == T_WR)
            begin
              nxt_drv = 1'b1; nxt_st = T_WR_ACK; nxt_first = 1'b0;
              nxt_op = first_ff; nxt_wr = ~first_ff;
            end
            else if (sh_ff[7:1] == own_addr_i)
            begin
              nxt_drv = 1'b1; nxt_st = T_ADDR_ACK; nxt_rw = sh_ff[0];
              nxt_rs = sh_ff[0];
            end
            else
              nxt_st = T_IDLE;
          end
        T_WR_ACK:
          if (fall)
          begin
            nxt_drv = 1'b0; nxt_cnt = 4'h0; nxt_st = T_WR;
          end
        T_ADDR_ACK, T_RD_ACK:
          if (rise && st_ff == T_RD_ACK)
          begin
            if (sda_i)
              nxt_st = T_IDLE;
            else
              nxt_rn = 1'b1;
          end
          else if (fall)
          begin
            nxt_cnt = 4'h0;
            if (rw_ff)
            begin
              nxt_st = T_RD; nxt_sh = ifc.rd_data; nxt_skip = ifc.rd_skip;
              nxt_drv = ~ifc.rd_data[7] & ~ifc.rd_skip;
            end
            else
            begin
              nxt_st = T_WR; nxt_drv = 1'b0;
            end
          end
        T_RD:
          if (rise)
            nxt_cnt = cnt_ff + 4'h1;
          else if (fall)
          begin
            if (cnt_ff == 4'h8)
            begin
              nxt_drv = 1'b0; nxt_st = T_RD_ACK;
            end
            else
            begin
              nxt_sh = {sh_ff[6:0], 1'b0}; nxt_drv = ~sh_ff[6] & ~skip_ff;
            end
          end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= T_IDLE; cnt_ff <= 4'h0; sh_ff <= 8'h00; drv_ff <= 1'b0;
      rw_ff <= 1'b0; first_ff <= 1'b0; skip_ff <= 1'b0;
      scl_d_ff <= 1'b1; sda_d_ff <= 1'b1;
      op_ff <= 1'b0; wr_ff <= 1'b0; rs_ff <= 1'b0; rn_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st; cnt_ff <= nxt_cnt; sh_ff <= nxt_sh; drv_ff <= nxt_drv;
      rw_ff <= nxt_rw; first_ff <= nxt_first; skip_ff <= nxt_skip;
      scl_d_ff <= scl_i; sda_d_ff <= sda_i;
      op_ff <= nxt_op; wr_ff <= nxt_wr; rs_ff <= nxt_rs; rn_ff <= nxt_rn;
    end
  end

  assign ifc.evt_op    = op_ff;
  assign ifc.evt_wr    = wr_ff;
  assign ifc.rd_start  = rs_ff;
  assign ifc.rd_next   = rn_ff;
  assign ifc.data_byte = sh_ff;
  assign ifc.sda_drive = drv_ff;
endmodule
`default_nettype wire

//--- touch_sensor_command_control.sv
// Operation
// - channels are raced one after another against the shared reference element
// - reference trips first gives an up step, sensor first a down step
// - each channel counts same-direction steps, restarting on direction reversal
// - active flag sets only after 64 uninterrupted up steps
// - sample spacing follows the oscillator tuning register
// - touch state holds the flags; any state change raises the interrupt, only a new touch while INTM_BIT is set
// - opcode 00h is a data-less soft reset
// - soft reset restores channels and registers, ends interrupt-over-bus mode
// - opcode 03h releases the active-low interrupt output
// - sleep on opcode 05h or pin high, resume on 06h or pin low
// - command sleep and pin sleep are held apart, each ended by its source
// - sleep stops oscillator and regulator, keeps registers and bus answers
// - leaving sleep reruns start-up with fast reservoir charging
// - opcode 30h writes setup byte, 33h reads it back
// - opcode 35h writes tuning byte, 36h reads it back
// - opcode 39h writes channel mask byte, 3Ah reads it back
// - opcode 3Ch enters interrupt-over-bus mode
// - tuning and mask change only by their write commands and by reset
// - read transfer returns touch state and releases the interrupt
// - every further read byte repeats the source of the first byte (touch state or the register selected by 33h/36h/3Ah)
// - cascaded devices alternate bytes within one read
// - no reset pin; power-on reset and soft reset only
// - direct mode bit follows activation and release without a read
// - address select pin is the address LSB
`timescale 1ns/1ps
`default_nettype none
module touch_sensor_command_control (
  input  wire logic                                 mclk_i,
  input  wire logic                                 rst_i,
  input  wire logic                                 scl_i,
  input  wire logic                                 sda_i,
  output logic                                      sda_o,
  output logic                                      sda_oe_o,
  input  wire logic                                 addr_select_pin_i,
  input  wire logic                                 sleep_pin_i,
  input  wire logic                                 ref_cmp_i,
  input  wire logic [touch_ctrl_pkg::NUM_CH-1:0]    sense_cmp_i,
  output logic                                      rc_charge_o,
  output logic [touch_ctrl_pkg::CH_IDX_W-1:0]       sample_sel_o,
  output logic [touch_ctrl_pkg::NUM_CH-1:0]         up_step_pulse_o,
  output logic [touch_ctrl_pkg::NUM_CH-1:0]         down_step_pulse_o,
  output logic [touch_ctrl_pkg::NUM_CH-1:0]         channel_active_flags_o,
  output logic                                      fast_charge_o,
  output logic                                      osc_en_o,
  output logic                                      vreg_en_o,
  output logic                                      int_n_o,
  output logic                                      int_over_bus_o,
  output logic [7:0]                                setup_o,
  output logic [7:0]                                osc_tuning_o
);
  import touch_ctrl_pkg::*;

  typedef enum logic [1:0] {SC_START, SC_CHARGE, SC_RACE, SC_GAP} scan_t;

  logic [SYNC_W-1:0]   sync1_ff, sync2_ff;
  logic                scl_s, sda_s, a0_s, sleep_s, ref_s;
  logic [NUM_CH-1:0]   sense_s;
  logic                rst_all;
  logic [NUM_CH-1:0]   active;

  logic [7:0]          setup_ff, nxt_setup, tune_ff, nxt_tune, chmask_ff, nxt_chmask;
  logic [7:0]          last_op_ff, nxt_last_op;
  logic                cmd_sleep_ff, nxt_cmd_sleep, int_bus_ff, nxt_int_bus;
  logic                soft_rst_ff, nxt_soft_rst, rd_odd_ff, nxt_rd_odd;
  rd_src_t             rd_sel_ff, nxt_rd_sel, cur_src_ff, nxt_cur_src;

  logic [NUM_CH-1:0]   touch_ff, nxt_touch, rise_act, chg;
  logic                pend_ff, nxt_pend, int_n_ff, nxt_int_n, touch_state_reg_rd, clr_int;
  logic [NUM_CH-1:0]   flags_ff;

  scan_t               sc_ff, nxt_sc;
  logic [TIMER_W-1:0]  timer_ff, nxt_timer, gap_len;
  logic [CH_IDX_W-1:0] ch_ff, nxt_ch;
  logic                charge_ff, nxt_charge, fast_ff, nxt_fast, osc_ff, nxt_osc;
  logic [NUM_CH-1:0]   up_ff, nxt_up, dn_ff, nxt_dn;
  logic                asleep;

  i2c_cmd_if bus_if ();

  // pin inputs pass two flops before use
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end
    else
    begin
      sync1_ff <= {scl_i, sda_i, addr_select_pin_i, sleep_pin_i, ref_cmp_i, sense_cmp_i};
      sync2_ff <= sync1_ff;
    end
  end
  assign {scl_s, sda_s, a0_s, sleep_s, ref_s, sense_s} = sync2_ff;

  // power-on reset plus the registered soft reset pulse
  assign rst_all = rst_i | soft_rst_ff;

  i2c_target u_target (
    .clk_i      (mclk_i),
    .rst_i      (rst_i),
    .scl_i      (scl_s),
    .sda_i      (sda_s),
    .own_addr_i ({ADDR_BASE, a0_s}),
    .ifc        (bus_if.target)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      channel_run u_run (
        .clk_i    (mclk_i),
        .rst_i    (rst_all),
        .up_i     (up_ff[g]),
        .down_i   (dn_ff[g]),
        .active_o (active[g])
      );
    end
  endgenerate

  // command decode and register file
  always_comb
  begin
    nxt_setup = setup_ff; nxt_tune = tune_ff; nxt_chmask = chmask_ff;
    nxt_last_op = last_op_ff; nxt_cmd_sleep = cmd_sleep_ff; nxt_int_bus = int_bus_ff;
    nxt_soft_rst = 1'b0; nxt_rd_sel = rd_sel_ff; nxt_cur_src = cur_src_ff;
    nxt_rd_odd = rd_odd_ff;
    if (bus_if.evt_op)
    begin
      nxt_last_op = bus_if.data_byte;
      case (bus_if.data_byte)
        OP_SOFT_RESET: nxt_soft_rst = 1'b1;
        OP_SLEEP:      nxt_cmd_sleep = 1'b1;
        OP_WAKE:       nxt_cmd_sleep = 1'b0;
        OP_INT_BUS:    nxt_int_bus = 1'b1;
        OP_RD_SETUP:   nxt_rd_sel = SRC_SETUP;
        OP_RD_TUNE:    nxt_rd_sel = SRC_TUNE;
        OP_RD_CHMASK:  nxt_rd_sel = SRC_CHMASK;
        default:       ;
      endcase
    end
    if (bus_if.evt_wr)
    begin
      case (last_op_ff)
        OP_WR_SETUP:  nxt_setup = bus_if.data_byte;
        OP_WR_TUNE:   nxt_tune = bus_if.data_byte;
        OP_WR_CHMASK: nxt_chmask = bus_if.data_byte;
        default:      ;
      endcase
    end
    if (bus_if.rd_start)
    begin
      nxt_cur_src = rd_sel_ff;
      nxt_rd_sel  = SRC_SENSOR;
      nxt_rd_odd  = 1'b0;
    end
    else if (bus_if.rd_next)
      nxt_rd_odd = ~rd_odd_ff;
  end

  always_comb
  begin
    bus_if.rd_data = touch_ff;
    unique case (cur_src_ff)
      SRC_SENSOR: bus_if.rd_data = touch_ff;
      SRC_SETUP:  bus_if.rd_data = setup_ff;
      SRC_TUNE:   bus_if.rd_data = tune_ff;
      SRC_CHMASK: bus_if.rd_data = chmask_ff;
    endcase
    // primary answers even bytes, secondary odd ones
    bus_if.rd_skip = (setup_ff[OPM_HI:OPM_LO] == OPM_PRIMARY && rd_odd_ff) ||
                     (setup_ff[OPM_HI:OPM_LO] == OPM_SECONDARY && !rd_odd_ff);
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      setup_ff <= SETUP_RST; tune_ff <= TUNE_RST; chmask_ff <= CHMASK_RST;
      last_op_ff <= OP_SOFT_RESET; cmd_sleep_ff <= 1'b0; int_bus_ff <= 1'b0;
      rd_sel_ff <= SRC_SENSOR; cur_src_ff <= SRC_SENSOR; rd_odd_ff <= 1'b0;
    end
    else
    begin
      setup_ff <= nxt_setup; tune_ff <= nxt_tune; chmask_ff <= nxt_chmask;
      last_op_ff <= nxt_last_op; cmd_sleep_ff <= nxt_cmd_sleep; int_bus_ff <= nxt_int_bus;
      rd_sel_ff <= nxt_rd_sel; cur_src_ff <= nxt_cur_src; rd_odd_ff <= nxt_rd_odd;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      soft_rst_ff <= 1'b0;
    else
      soft_rst_ff <= nxt_soft_rst;
  end

  // touch state and interrupt
  always_comb
  begin
    touch_state_reg_rd  = bus_if.rd_start && rd_sel_ff == SRC_SENSOR;
    clr_int  = (bus_if.evt_op && bus_if.data_byte == OP_CLR_INT) || touch_state_reg_rd;
    rise_act = active & ~flags_ff;
    if (setup_ff[SWM_BIT])
      nxt_touch = (touch_ff & ~{NUM_CH{touch_state_reg_rd}}) | rise_act;
    else
      nxt_touch = active;
    if (setup_ff[INTM_BIT])
      chg = nxt_touch & ~touch_ff;
    else
      chg = nxt_touch ^ touch_ff;
    nxt_pend  = (|chg) | (pend_ff & ~clr_int);
    nxt_int_n = ~(nxt_pend & ~nxt_int_bus);
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      touch_ff <= TOUCH_RST; pend_ff <= 1'b0; int_n_ff <= 1'b1; flags_ff <= '0;
    end
    else
    begin
      touch_ff <= nxt_touch; pend_ff <= nxt_pend; int_n_ff <= nxt_int_n; flags_ff <= active;
    end
  end

  // sleep control and channel scan
  assign asleep  = cmd_sleep_ff | sleep_s;
  assign gap_len = GAP_CYC + {4'h0, tune_ff[4:0], 3'h0};

  always_comb
  begin
    nxt_sc = sc_ff; nxt_timer = timer_ff; nxt_ch = ch_ff;
    nxt_charge = 1'b0; nxt_fast = 1'b0; nxt_up = '0; nxt_dn = '0;
    nxt_osc = ~asleep;
    if (asleep)
    begin
      nxt_sc = SC_START; nxt_timer = STARTUP_CYC;
    end
    else
    begin
      unique case (sc_ff)
        SC_START:
          if (timer_ff == '0)
          begin
            nxt_sc = SC_CHARGE; nxt_timer = CHARGE_CYC - 12'h001; nxt_charge = 1'b1;
          end
          else
          begin
            nxt_fast = 1'b1; nxt_timer = timer_ff - 12'h001;
          end
        SC_CHARGE:
          if (!chmask_ff[ch_ff])
          begin
            nxt_sc = SC_GAP; nxt_timer = gap_len;
          end
          else if (timer_ff == '0)
          begin
            nxt_sc = SC_RACE; nxt_timer = RACE_CYC - 12'h001;
          end
          else
          begin
            nxt_charge = 1'b1; nxt_timer = timer_ff - 12'h001;
          end
        SC_RACE:
          if (sense_s[ch_ff])
          begin
            nxt_dn[ch_ff] = 1'b1; nxt_sc = SC_GAP; nxt_timer = gap_len;
          end
          else if (ref_s)
          begin
            nxt_up[ch_ff] = 1'b1; nxt_sc = SC_GAP; nxt_timer = gap_len;
          end
          else if (timer_ff == '0)
          begin
            nxt_sc = SC_GAP; nxt_timer = gap_len;
          end
          else
            nxt_timer = timer_ff - 12'h001;
        SC_GAP:
          if (timer_ff == '0)
          begin
            nxt_ch = ch_ff + 3'h1;
            nxt_sc = SC_CHARGE; nxt_timer = CHARGE_CYC - 12'h001; nxt_charge = 1'b1;
          end
          else
            nxt_timer = timer_ff - 12'h001;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sc_ff <= SC_START; timer_ff <= STARTUP_CYC; ch_ff <= '0; charge_ff <= 1'b0;
      fast_ff <= 1'b0; osc_ff <= 1'b0; up_ff <= '0; dn_ff <= '0;
    end
    else
    begin
      sc_ff <= nxt_sc; timer_ff <= nxt_timer; ch_ff <= nxt_ch; charge_ff <= nxt_charge;
      fast_ff <= nxt_fast; osc_ff <= nxt_osc; up_ff <= nxt_up; dn_ff <= nxt_dn;
    end
  end

  assign sda_o                  = 1'b0;
  assign sda_oe_o               = bus_if.sda_drive;
  assign rc_charge_o            = charge_ff;
  assign sample_sel_o           = ch_ff;
  assign up_step_pulse_o        = up_ff;
  assign down_step_pulse_o      = dn_ff;
  assign channel_active_flags_o = flags_ff;
  assign fast_charge_o          = fast_ff;
  assign osc_en_o               = osc_ff;
  assign vreg_en_o              = osc_ff;
  assign int_n_o                = int_n_ff;
  assign int_over_bus_o         = int_bus_ff;
  assign setup_o                = setup_ff;
  assign osc_tuning_o           = tune_ff;
endmodule
`default_nettype wire

//--- touch_ctrl_pkg_unused_guard.sv
`default_nettype none
`default_nettype wire

//--- touch_sensor_command_control_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module touch_sensor_command_control_assertions (
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       scl_i,
  input wire logic       sleep_pin_i,
  input wire logic       sda_oe_o,
  input wire logic [7:0] up_step_pulse_o,
  input wire logic [7:0] down_step_pulse_o,
  input wire logic [7:0] channel_active_flags_o,
  input wire logic       fast_charge_o,
  input wire logic       osc_en_o,
  input wire logic       int_n_o,
  input wire logic       int_over_bus_o
);
  logic [7:0] fl_ff;
  logic [3:0] since_ff;
  logic [3:0] nxt_since;
  // cycles since the flags last changed, saturating
  always_comb
  begin
    nxt_since = since_ff;
    if (channel_active_flags_o != fl_ff)
      nxt_since = 4'h0;
    else if (since_ff != 4'hf)
      nxt_since = since_ff + 4'h1;
  end
  always_ff @(posedge mclk_i)
  begin
    fl_ff    <= rst_i ? 8'h00 : channel_active_flags_o;
    since_ff <= rst_i ? 4'hf : nxt_since;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_pin_sleep;
    sleep_pin_i [*6];
  endsequence
  sequence s_wake;
    $rose(osc_en_o);
  endsequence
  a_one_channel: assert property ($onehot0(up_step_pulse_o | down_step_pulse_o))
    else $error("pulses on two channels");
  a_step_single: assert property (|up_step_pulse_o |=> !(|up_step_pulse_o))
    else $error("up step longer than one cycle");
  a_flag_cause: assert property (|(channel_active_flags_o & ~$past(channel_active_flags_o))
    |-> $past(|up_step_pulse_o) || $past(|up_step_pulse_o, 2) || $past(|up_step_pulse_o, 3))
    else $error("flag rose without up step");
  a_int_change: assert property ($fell(int_n_o) |-> nxt_since < 4'h5)
    else $error("interrupt without state change");
  a_pin_sleep: assert property (s_pin_sleep |-> !osc_en_o)
    else $error("oscillator on during pin sleep");
  a_wake_start: assert property (s_wake |-> ##[0:3] fast_charge_o)
    else $error("no fast charge after wake");
  a_bus_int_high: assert property (int_over_bus_o && $past(int_over_bus_o) |-> int_n_o)
    else $error("interrupt pin low in bus mode");
  a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data changed while clock high");
endmodule
bind touch_sensor_command_control touch_sensor_command_control_assertions u_assertions (
  .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i), .sleep_pin_i(sleep_pin_i),
  .sda_oe_o(sda_oe_o), .up_step_pulse_o(up_step_pulse_o),
  .down_step_pulse_o(down_step_pulse_o), .channel_active_flags_o(channel_active_flags_o),
  .fast_charge_o(fast_charge_o), .osc_en_o(osc_en_o), .int_n_o(int_n_o),
  .int_over_bus_o(int_over_bus_o));
`default_nettype wire

//--- i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // clock stands high and data is released between frames
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic start();
    sda_low_o = 1'b1;
    tick(2);
    scl_o = 1'b0;
    tick(2);
  endtask
  task automatic xbit(input logic b, output logic r);
    sda_low_o = !b;
    tick(2);
    scl_o = 1'b1;
    tick(2);
    r = sda_i;
    tick(2);
    scl_o = 1'b0;
    tick(2);
  endtask
  task automatic xbyte(input logic [7:0] w, input logic mack, output logic [7:0] r,
                       output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      xbit(w[i], r[i]);
    xbit(!mack, a);
    ack = !a;
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    tick(2);
    scl_o = 1'b1;
    tick(2);
    sda_low_o = 1'b0;
    tick(4);
  endtask
endmodule
`default_nettype wire

//--- touch_sensor_command_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module touch_sensor_command_control_bench;
  import touch_ctrl_pkg::*;
  logic       mclk_i, rst_i, a0, slp, ref_c, touch, m_low, scl, oe, osc, fch, int_n, iob, rc, k;
  logic [7:0] up, dn, fl, setup, tune, sense, b0, b1;
  logic [2:0] sel;
  logic       vreg;
  int         run = 0;
  int         n_mismatch = 0;
  int         n_tests = 0;
  wire logic  sda = !(oe | m_low);
  localparam logic [7:0] WO [3] = '{OP_WR_SETUP, OP_WR_TUNE, OP_WR_CHMASK};
  localparam logic [7:0] RO [3] = '{OP_RD_SETUP, OP_RD_TUNE, OP_RD_CHMASK};
  localparam logic [7:0] VAL [3] = '{8'h1c, 8'h00, 8'h01};
  touch_sensor_command_control u_touch_sensor_command_control (
    .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe),
    .addr_select_pin_i(a0), .sleep_pin_i(slp), .ref_cmp_i(ref_c), .sense_cmp_i(sense),
    .rc_charge_o(rc), .sample_sel_o(sel), .up_step_pulse_o(up), .down_step_pulse_o(dn),
    .channel_active_flags_o(fl), .fast_charge_o(fch), .osc_en_o(osc), .vreg_en_o(vreg),
    .int_n_o(int_n), .int_over_bus_o(iob), .setup_o(setup), .osc_tuning_o(tune));
  i2c_master_model u_i2c_master_model (
    .mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = !mclk_i;
  end
  // comparators trip once charging ends; a touched plate never trips
  always @(negedge mclk_i)
  begin
    ref_c <= !rc;
    sense <= touch ? 8'h00 : {8{!rc}};
  end
  always @(posedge mclk_i)
    run <= (dn[0] === 1'b1) ? 0 : run + int'(up[0] === 1'b1);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic wd, input logic [7:0] d);
    u_i2c_master_model.start();
    u_i2c_master_model.xbyte({ADDR_BASE, a0, 1'b0}, 1'b0, b1, k);
    chk({7'h0, k}, 8'h01);
    u_i2c_master_model.xbyte(op, 1'b0, b1, k);
    if (wd)
      u_i2c_master_model.xbyte(d, 1'b0, b1, k);
    u_i2c_master_model.stop();
  endtask
  task automatic rd();
    u_i2c_master_model.start();
    u_i2c_master_model.xbyte({ADDR_BASE, a0, 1'b1}, 1'b0, b0, k);
    u_i2c_master_model.xbyte(8'hff, 1'b1, b0, k);
    u_i2c_master_model.xbyte(8'hff, 1'b0, b1, k);
    u_i2c_master_model.stop();
  endtask
  task automatic wfl(input logic [7:0] e);
    for (int i = 0; i < 40000 && fl !== e; i++)
      @(negedge mclk_i);
    chk(fl, e);
  endtask
  task automatic t_regs();
    chk(setup, SETUP_RST);
    chk(tune, TUNE_RST);
    for (int i = 0; i < 3; i++)
    begin
      cmd(WO[i], 1'b1, VAL[i]);
      cmd(RO[i], 1'b0, 8'h00);
      rd();
      chk(b0, VAL[i]);
      chk(b1, VAL[i]);
    end
    chk(setup, 8'h1c);
    chk(tune, 8'h00);
    $display("register test done");
  endtask
  task automatic t_touch();
    touch = 1'b1;
    wfl(8'h01);
    chk(run[7:0], 8'h40);
    chk({5'h0, sel}, 8'h00);
    u_i2c_master_model.tick(8);
    chk({7'h0, int_n}, 8'h00);
    rd();
    chk(b0, 8'h01);
    chk(b1, 8'h01);
    chk({7'h0, int_n}, 8'h01);
    touch = 1'b0;
    wfl(8'h00);
    u_i2c_master_model.tick(8);
    chk({7'h0, int_n}, 8'h00);
    cmd(OP_CLR_INT, 1'b0, 8'h00);
    chk({7'h0, int_n}, 8'h01);
    $display("touch test done");
  endtask
  task automatic t_sleep();
    cmd(OP_SLEEP, 1'b0, 8'h00);
    chk({6'h0, vreg, osc}, 8'h00);
    slp = 1'b1;
    u_i2c_master_model.tick(8);
    slp = 1'b0;
    u_i2c_master_model.tick(8);
    chk({7'h0, osc}, 8'h00);
    cmd(OP_RD_SETUP, 1'b0, 8'h00);
    rd();
    chk(b0, 8'h1c);
    cmd(OP_WAKE, 1'b0, 8'h00);
    chk({5'h0, vreg, osc, fch}, 8'h07);
    slp = 1'b1;
    cmd(OP_WAKE, 1'b0, 8'h00);
    chk({7'h0, osc}, 8'h00);
    slp = 1'b0;
    u_i2c_master_model.tick(8);
    chk({7'h0, osc}, 8'h01);
    $display("sleep test done");
  endtask
  task automatic t_reset();
    cmd(OP_INT_BUS, 1'b0, 8'h00);
    chk({7'h0, iob}, 8'h01);
    cmd(OP_WR_SETUP, 1'b1, 8'h40);
    rd();
    chk(b0, 8'hff);
    chk(b1, 8'h00);
    cmd(OP_SOFT_RESET, 1'b0, 8'h00);
    chk({7'h0, iob}, 8'h00);
    chk(setup, SETUP_RST);
    chk(tune, TUNE_RST);
    a0 = 1'b1;
    u_i2c_master_model.start();
    u_i2c_master_model.xbyte({ADDR_BASE, 1'b0, 1'b0}, 1'b0, b0, k);
    u_i2c_master_model.stop();
    chk({7'h0, k}, 8'h00);
    cmd(OP_RD_CHMASK, 1'b0, 8'h00);
    rd();
    chk(b0, CHMASK_RST);
    $display("reset test done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    {rst_i, a0, slp, touch} = {1'b1, 3'h0};
    repeat (4) @(negedge mclk_i);
    rst_i = 1'b0;
    u_i2c_master_model.tick(4);
    t_regs();
    t_touch();
    t_sleep();
    t_reset();
    wrap_up();
  end
  // the touch run needs about 30k cycles; the 100k-cycle limit is about three times the whole run
  initial
  begin
    #2000000;
    n_mismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire
